/* inc/glc_defs.svh */
/*
  Constants of the guard lock output controller: register offsets,
  field positions, reset values and timing counts.
  Assumes a 20 MHz system clock; the counts derive from it.
*/
`ifndef GLC_DEFS_SVH
`define GLC_DEFS_SVH

`define GLC_CLK_HZ           20000000
// test pulse is a longest time: rounds down
`define GLC_TP_MAX_US        1000
`define GLC_TP_LEN_CYC       (`GLC_TP_MAX_US * (`GLC_CLK_HZ / 1000000))
`define GLC_TP_PERIOD_MS     100
`define GLC_TP_PERIOD_CYC    (`GLC_TP_PERIOD_MS * (`GLC_CLK_HZ / 1000))
// activation pulses up to this length are ignored
`define GLC_FILT_MS          5
`define GLC_FILT_CYC         (`GLC_FILT_MS * (`GLC_CLK_HZ / 1000))
`define GLC_BLINK_HZ         5
`define GLC_BLINK_HALF_CYC   (`GLC_CLK_HZ / (2 * `GLC_BLINK_HZ))
`define GLC_INIT_MS          1000
`define GLC_INIT_CYC         (`GLC_INIT_MS * (`GLC_CLK_HZ / 1000))

`define GLC_ADDR_W           4
`define GLC_CTRL_OFS         4'h0
`define GLC_STATUS_OFS       4'h4
`define GLC_FCLR_OFS         4'h8

`define GLC_CTRL_INHIBIT_BIT 0
`define GLC_CTRL_RST         1'h0
`define GLC_FCLR_BIT         0

`define GLC_ST_DOOR_BIT      0
`define GLC_ST_LOCK_BIT      1
`define GLC_ST_FAULT_BIT     2
`define GLC_ST_ON_BIT        3
`define GLC_ST_ACT_BIT       4
`define GLC_ST_RUN_BIT       5
`define GLC_ST_INH_BIT       6

`endif

/* inc/glc_pkg.sv */
/*
  Types of the guard lock output controller.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package glc_pkg;

  typedef enum logic [1:0] {
    GLC_INIT = 2'h1,
    GLC_RUN  = 2'h2
  } glc_state_t;

endpackage

/* hdl/glc_top.sv */
/*
  Guard lock output controller: combines guard presence, lock state and
  faults into a staggered, test-pulsed safety output pair and three
  diagnostic outputs, with an Avalon-MM slave for control and status.
  Assumes inputs synchronous to sys_clk and a power-up synchronous reset.
*/
// Decided for this implementation: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`include "glc_defs.svh"

module glc_top #(
  parameter int FILT_CYC       = `GLC_FILT_CYC,
  parameter int TP_LEN_CYC     = `GLC_TP_LEN_CYC,
  parameter int TP_PERIOD_CYC  = `GLC_TP_PERIOD_CYC,
  parameter int BLINK_HALF_CYC = `GLC_BLINK_HALF_CYC,
  parameter int INIT_CYC       = `GLC_INIT_CYC
) (
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  input  wire logic                    actuator_in_range,
  input  wire logic                    code_valid,
  input  wire logic                    solenoid_act_a,
  input  wire logic                    solenoid_act_b,
  input  wire logic                    internal_fault,
  input  wire logic [`GLC_ADDR_W-1:0]  avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  output logic      [31:0]             avs_readdata,
  output logic                         avs_waitrequest,
  output logic                         safety_output_a,
  output logic                         safety_output_b,
  output logic                         door_diag_out,
  output logic                         lock_diag_out,
  output logic                         fault_diag_out,
  output logic                         status_led_green
);

  localparam int TP_HALF = TP_PERIOD_CYC / 2;

  // pulse window of one output inside the shared test period
  function automatic logic in_window(input logic [31:0] cnt,
                                     input int          start);
    in_window = (cnt >= 32'(start)) && (cnt < 32'(start + TP_LEN_CYC));
  endfunction

  glc_pkg::glc_state_t state_q, state_d;
  logic [31:0] init_cnt_q, init_cnt_d;
  logic [31:0] blink_cnt_q, blink_cnt_d;
  logic        led_q, led_d;
  logic [31:0] tp_cnt_q, tp_cnt_d;
  logic        tp_a_q, tp_a_d;
  logic        tp_b_q, tp_b_d;
  logic        act_filt_q, act_filt_d;
  logic [31:0] flt_cnt_q, flt_cnt_d;
  logic [31:0] mis_cnt_q, mis_cnt_d;
  logic        door_q, door_d;
  logic        lock_q, lock_d;
  logic        fault_q, fault_d;
  logic        on_q, on_d;
  logic        sa_q, sa_d;
  logic        sb_q, sb_d;
  logic        inhibit_q, inhibit_d;
  logic        wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic        act_raw;
  logic        mis_hit;
  logic        bus_req;
  logic        bus_fire;
  logic        fclr_wr;
  logic        run_d;
  logic [31:0] status_w;

  assign act_raw  = solenoid_act_a & solenoid_act_b;
  assign bus_req  = avs_read | avs_write;
  assign bus_fire = bus_req & ~wait_q;
  assign fclr_wr  = bus_fire & avs_write
                    & (avs_address == `GLC_FCLR_OFS)
                    & avs_writedata[`GLC_FCLR_BIT];

  always_comb begin
    status_w = 32'h0;
    status_w[`GLC_ST_DOOR_BIT]  = door_q;
    status_w[`GLC_ST_LOCK_BIT]  = lock_q;
    status_w[`GLC_ST_FAULT_BIT] = fault_q;
    status_w[`GLC_ST_ON_BIT]    = on_q;
    status_w[`GLC_ST_ACT_BIT]   = act_filt_q;
    status_w[`GLC_ST_RUN_BIT]   = (state_q == glc_pkg::GLC_RUN);
    status_w[`GLC_ST_INH_BIT]   = inhibit_q;
  end

  always_comb begin
    // power-up initialisation and status indicator
    state_d     = state_q;
    init_cnt_d  = init_cnt_q;
    blink_cnt_d = blink_cnt_q;
    led_d       = led_q;
    unique case (state_q)
      glc_pkg::GLC_INIT: begin
        blink_cnt_d = blink_cnt_q + 32'h1;
        if (blink_cnt_q == 32'(BLINK_HALF_CYC - 1)) begin
          blink_cnt_d = 32'h0;
          led_d       = ~led_q;
        end
        init_cnt_d = init_cnt_q + 32'h1;
        if (init_cnt_q == 32'(INIT_CYC - 1)) begin
          state_d = glc_pkg::GLC_RUN;
        end
      end
      glc_pkg::GLC_RUN: begin
        led_d = 1'b1;
      end
      default: begin
        state_d = glc_pkg::GLC_INIT;
      end
    endcase
    run_d = (state_d == glc_pkg::GLC_RUN);

    // free-running test period; runs in off state too
    tp_cnt_d = (tp_cnt_q == 32'(TP_PERIOD_CYC - 1)) ? 32'h0
                                                   : tp_cnt_q + 32'h1;
    tp_a_d = run_d & in_window(tp_cnt_d, 0);
    tp_b_d = run_d & in_window(tp_cnt_d, TP_HALF);

    // activation only changes after holding longer than the filter
    flt_cnt_d  = 32'h0;
    act_filt_d = act_filt_q;
    if (act_raw != act_filt_q) begin
      flt_cnt_d = flt_cnt_q + 32'h1;
      if (flt_cnt_q == 32'(FILT_CYC)) begin
        act_filt_d = act_raw;
        flt_cnt_d  = 32'h0;
      end
    end

    // channels disagreeing longer than the filter are a fault
    mis_cnt_d = 32'h0;
    mis_hit   = 1'b0;
    if (solenoid_act_a != solenoid_act_b) begin
      mis_cnt_d = mis_cnt_q + 32'h1;
      if (mis_cnt_q == 32'(FILT_CYC)) begin
        mis_hit   = 1'b1;
        mis_cnt_d = mis_cnt_q;
      end
    end

    door_d = actuator_in_range & code_valid;
    // power-to-release: closed guard and no activation means locked
    lock_d = door_d & ~act_filt_d;
    // a new fault beats a clear in the same cycle
    fault_d = internal_fault | mis_hit | (fault_q & ~fclr_wr);
    on_d = run_d & door_d & lock_d & ~fault_d
           & ~inhibit_q;
    // off state shows pulses as short highs, on state as short lows
    sa_d = on_d ^ tp_a_d;
    sb_d = on_d ^ tp_b_d;

    // avalon slave: one wait state, then answer
    wait_d    = 1'b1;
    rdata_d   = rdata_q;
    inhibit_d = inhibit_q;
    if (bus_req & wait_q) begin
      wait_d = 1'b0;
      unique case (avs_address)
        `GLC_CTRL_OFS:   rdata_d = {31'h0, inhibit_q};
        `GLC_STATUS_OFS: rdata_d = status_w;
        default:         rdata_d = 32'h0;
      endcase
    end
    if (bus_fire & avs_write & (avs_address == `GLC_CTRL_OFS)) begin
      inhibit_d = avs_writedata[`GLC_CTRL_INHIBIT_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q          <= glc_pkg::GLC_INIT;
      init_cnt_q       <= 32'h0;
      blink_cnt_q      <= 32'h0;
      led_q            <= 1'b0;
      tp_cnt_q         <= 32'h0;
      tp_a_q           <= 1'b0;
      tp_b_q           <= 1'b0;
      act_filt_q       <= 1'b0;
      flt_cnt_q        <= 32'h0;
      mis_cnt_q        <= 32'h0;
      door_q           <= 1'b0;
      lock_q           <= 1'b0;
      fault_q          <= 1'b0;
      on_q             <= 1'b0;
      sa_q             <= 1'b0;
      sb_q             <= 1'b0;
      inhibit_q        <= `GLC_CTRL_RST;
      wait_q           <= 1'b1;
      rdata_q          <= 32'h0;
    end else begin
      state_q          <= state_d;
      init_cnt_q       <= init_cnt_d;
      blink_cnt_q      <= blink_cnt_d;
      led_q            <= led_d;
      tp_cnt_q         <= tp_cnt_d;
      tp_a_q           <= tp_a_d;
      tp_b_q           <= tp_b_d;
      act_filt_q       <= act_filt_d;
      flt_cnt_q        <= flt_cnt_d;
      mis_cnt_q        <= mis_cnt_d;
      door_q           <= door_d;
      lock_q           <= lock_d;
      fault_q          <= fault_d;
      on_q             <= on_d;
      sa_q             <= sa_d;
      sb_q             <= sb_d;
      inhibit_q        <= inhibit_d;
      wait_q           <= wait_d;
      rdata_q          <= rdata_d;
    end
  end

  assign safety_output_a  = sa_q;
  assign safety_output_b  = sb_q;
  assign door_diag_out    = door_q;
  assign lock_diag_out    = lock_q;
  assign fault_diag_out   = fault_q;
  assign status_led_green = led_q;
  assign avs_readdata     = rdata_q;
  assign avs_waitrequest  = wait_q;

  // helper: length of the current pulse on output a
  logic [31:0] pa_len_q;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pa_len_q <= 32'h0;
    end else begin
      pa_len_q <= tp_a_q ? pa_len_q + 32'h1 : 32'h0;
    end
  end

  a_on_needs_lock: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    on_q |-> (door_q && lock_q && !fault_q))
    else $error("safety on without closed and locked guard");

  a_fault_forces_off: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    internal_fault |=> (!on_q && fault_q))
    else $error("safety on despite internal fault");

  a_pulse_bounded: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    tp_a_q |-> (pa_len_q < 32'(TP_LEN_CYC)))
    else $error("test pulse longer than allowed");

  a_pulse_when_off: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (!on_q && tp_a_q) |-> (safety_output_a && !safety_output_b))
    else $error("off state test pulse missing");

  a_act_filtered: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $changed(act_filt_q) |-> ($past(flt_cnt_q) == 32'(FILT_CYC)))
    else $error("activation changed before filter expired");

  a_lock_no_act: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (door_q && !act_filt_q) |-> lock_diag_out)
    else $error("lock released without activation");

  a_door_valid: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    door_diag_out |-> $past(actuator_in_range && code_valid))
    else $error("door diagnostic on without valid actuator");

  a_open_all_off: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !actuator_in_range |=> (!on_q && !lock_diag_out && !door_diag_out))
    else $error("outputs on with guard open");

  a_no_overlap: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !(tp_a_q && tp_b_q))
    else $error("test pulses overlap");

  a_init_off: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (state_q == glc_pkg::GLC_INIT) |-> (!safety_output_a && !on_q))
    else $error("safety output on during init");

  a_bus_answer: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (bus_req && wait_q) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not after one wait state");

  c_locked_on: cover property (
    @(posedge sys_clk) disable iff (!rst_n) $rose(on_q));
  c_fault_seen: cover property (
    @(posedge sys_clk) disable iff (!rst_n) $rose(fault_q));
  c_unlocked_closed: cover property (
    @(posedge sys_clk) disable iff (!rst_n) door_q && !lock_q);

endmodule

/* sim/glc_ctrl_model.sv */
/*
  Safety controller model facing the guard lock block.
  Assumes bench requests change just after a rising edge of sys_clk.
*/
`timescale 1ns/1ps

module glc_ctrl_model #(
  parameter int TP_LEN_CYC = 4
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic safety_output_a,
  input  wire logic safety_output_b,
  input  wire logic run_cmd,
  input  wire logic release_req,
  input  wire logic clk_pulse,
  input  wire logic split,
  output logic      solenoid_act_a,
  output logic      solenoid_act_b,
  output logic      machine_on
);
  int   n_a;
  int   n_b;
  logic st_a;
  logic st_b;
  logic rel;

  // a level only counts once it outlasts a test pulse
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      n_a <= 0;
      n_b <= 0;
      st_a <= 1'b0;
      st_b <= 1'b0;
      machine_on <= 1'b0;
      solenoid_act_a <= 1'b0;
      solenoid_act_b <= 1'b0;
    end else begin
      n_a <= (safety_output_a === st_a) ? 0 : n_a + 1;
      n_b <= (safety_output_b === st_b) ? 0 : n_b + 1;
      if (n_a >= TP_LEN_CYC) st_a <= safety_output_a;
      if (n_b >= TP_LEN_CYC) st_b <= safety_output_b;
      // either channel off stops the machine
      machine_on <= run_cmd && st_a && st_b;
      // own clocking only when the bench commands a pulse
      solenoid_act_a <= rel || clk_pulse || split;
      solenoid_act_b <= (rel || clk_pulse) && !split;
    end
  end

  // release only once the hazard has ended
  assign rel = release_req && !run_cmd && !machine_on;
endmodule

/* sim/tb_top.sv */
/*
  Self-checking bench of the guard lock output controller.
  Assumes glc_top, its defines and the controller model; counts shortened.
*/
`timescale 1ns/1ps
`include "glc_defs.svh"

module tb_top;
  localparam int FLT = 20;
  localparam int TPL = 4;
  localparam int TPP = 40;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        in_rng = 1'b1;
  logic        code_ok = 1'b1;
  logic        flt = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [31:0] q;
  logic        wreq, sa, sb, door, lock, fdiag, led, sol_a, sol_b, mon;
  logic        run_cmd = 1'b1;
  logic        rel = 1'b0;
  logic        cpulse = 1'b0;
  logic        split = 1'b0;
  int          err_total = 0;
  int          total_checks = 0;
  int          da, db, both, run, mx, tog;

  glc_top #(.FILT_CYC(FLT), .TP_LEN_CYC(TPL), .TP_PERIOD_CYC(TPP),
    .BLINK_HALF_CYC(5), .INIT_CYC(50)) glc_top_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .actuator_in_range(in_rng),
    .code_valid(code_ok), .solenoid_act_a(sol_a), .solenoid_act_b(sol_b),
    .internal_fault(flt), .avs_address(addr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wdata), .avs_readdata(rdata),
    .avs_waitrequest(wreq), .safety_output_a(sa), .safety_output_b(sb),
    .door_diag_out(door), .lock_diag_out(lock), .fault_diag_out(fdiag),
    .status_led_green(led));

  glc_ctrl_model #(.TP_LEN_CYC(TPL)) glc_ctrl_model_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .safety_output_a(sa),
    .safety_output_b(sb), .run_cmd(run_cmd), .release_req(rel),
    .clk_pulse(cpulse), .split(split), .solenoid_act_a(sol_a),
    .solenoid_act_b(sol_b), .machine_on(mon));

  always #25 sys_clk = ~sys_clk;

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic tend(input string nm);
    $display("test %s done", nm);
  endtask

  // holds the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    int i;
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge sys_clk);
      if (wreq === 1'b0) break;
    end
    if (i == 20) begin
      chk("bus_timeout", 32'h0, 32'h1);
      end_of_test();
    end else begin
      // answer edge: data taken here, request dropped right after it
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      // one idle edge so the next call never re-raises in this step
      @(posedge sys_clk);
    end
  endtask

  // counts departures of both outputs from level lv and led toggles
  task automatic watch(input logic lv, input int n);
    logic pl;
    da = 0;
    db = 0;
    both = 0;
    run = 0;
    mx = 0;
    tog = 0;
    pl = led;
    repeat (n) begin
      @(negedge sys_clk);
      da += (sa !== lv);
      db += (sb !== lv);
      both += (sa !== lv && sb !== lv);
      run = (sa !== lv) ? run + 1 : 0;
      if (run > mx) mx = run;
      tog += (led !== pl);
      pl = led;
    end
    @(posedge sys_clk);
  endtask

  task automatic level(input logic lv);
    watch(lv, TPP);
    chk("pulse_len", 32'h1, 32'(mx <= TPL));
    chk("b_dev", 32'h1, 32'(db <= TPL));
    chk("overlap", 32'h0, 32'(both));
  endtask

  initial begin
    cyc(10);
    rst_n <= 1'b1;
    cyc(1);
    chk("wreq", 32'h1, 32'(wreq));
    watch(1'b0, 20);
    chk("init_a", 32'h0, 32'(da + db));
    chk("led_tog", 32'h4, 32'(tog));
    tend("init");
    cyc(35);
    level(1'b1);
    chk("a_pulses", 32'h1, 32'(da > 0));
    chk("machine_on", 32'h1, 32'(mon));
    chk("led_run", 32'h1, 32'(led));
    chk("door", 32'h1, 32'(door));
    chk("lock", 32'h1, 32'(lock));
    chk("fdiag", 32'h0, 32'(fdiag));
    bus(1'b0, `GLC_STATUS_OFS, 32'h0);
    chk("status", 32'h2B, q);
    tend("locked");
    cpulse <= 1'b1;
    cyc(FLT);
    cpulse <= 1'b0;
    cyc(FLT + 4);
    chk("lock", 32'h1, 32'(lock));
    rel <= 1'b1;
    cyc(FLT + 4);
    chk("sol_a", 32'h0, 32'(sol_a));
    run_cmd <= 1'b0;
    cyc(FLT + 6);
    chk("lock", 32'h0, 32'(lock));
    chk("door", 32'h1, 32'(door));
    level(1'b0);
    chk("off_pulses", 32'h1, 32'(da > 0));
    bus(1'b0, `GLC_STATUS_OFS, 32'h0);
    chk("status", 32'h31, q);
    rel <= 1'b0;
    cyc(FLT + 4);
    chk("lock", 32'h1, 32'(lock));
    level(1'b1);
    tend("release");
    in_rng <= 1'b0;
    cyc(3);
    chk("door", 32'h0, 32'(door));
    chk("lock", 32'h0, 32'(lock));
    level(1'b0);
    in_rng <= 1'b1;
    code_ok <= 1'b0;
    cyc(3);
    chk("door", 32'h0, 32'(door));
    chk("lock", 32'h0, 32'(lock));
    code_ok <= 1'b1;
    cyc(3);
    chk("door", 32'h1, 32'(door));
    chk("lock", 32'h1, 32'(lock));
    tend("guard");
    flt <= 1'b1;
    cyc(2);
    flt <= 1'b0;
    cyc(2);
    chk("fdiag", 32'h1, 32'(fdiag));
    level(1'b0);
    bus(1'b1, `GLC_FCLR_OFS, 32'h1);
    cyc(2);
    chk("fdiag", 32'h0, 32'(fdiag));
    split <= 1'b1;
    cyc(FLT + 5);
    split <= 1'b0;
    cyc(2);
    chk("split", 32'h1, 32'(fdiag));
    cyc(4);
    bus(1'b1, `GLC_FCLR_OFS, 32'h1);
    cyc(2);
    chk("fdiag", 32'h0, 32'(fdiag));
    tend("fault");
    bus(1'b1, `GLC_CTRL_OFS, 32'h1);
    level(1'b0);
    bus(1'b0, `GLC_CTRL_OFS, 32'h0);
    chk("ctrl", 32'h1, q);
    bus(1'b1, 4'hC, 32'hFFFFFFFF);
    bus(1'b0, 4'hC, 32'h0);
    chk("unmapped", 32'h0, q);
    bus(1'b0, `GLC_FCLR_OFS, 32'h0);
    chk("fclr", 32'h0, q);
    bus(1'b1, `GLC_CTRL_OFS, 32'h0);
    cyc(3);
    level(1'b1);
    tend("regs");
    end_of_test();
  end
endmodule
